// ===== logic/speed_monitor_pkg.sv
/*
 * Constants, types and register map of the speed sensor fault monitor.
 * Assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none

package speed_monitor_pkg;

	// ---------------------------------------------
	// Time base
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

	// ---------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TO_SIGNAL = 8'h04;
	localparam logic [7:0] OFS_TO_TRACK = 8'h08;
	localparam logic [7:0] OFS_TO_DIR = 8'h0c;
	localparam logic [7:0] OFS_LINES = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ---------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------
	localparam int CTRL_ACK_BIT = 8;
	localparam int STAT_SHUT_BIT = 3;
	localparam int STAT_ARMED_BIT = 4;
	localparam int STAT_CODE_LSB = 16;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ERROR = 2'h2;
	localparam logic [15:0] TIMEOUT_RESET = 16'h03e8;
	localparam logic [15:0] TIMEOUT_MAX = 16'hfde8;
	localparam logic [15:0] LINES_RESET = 16'h0400;
	localparam logic [15:0] CODE_NONE = 16'h0000;
	localparam logic [15:0] CODE_SIGNAL = 16'h1430;
	localparam logic [15:0] CODE_DIR = 16'h1432;

	// Check indices
	localparam int CHK_SIGNAL = 0;
	localparam int CHK_TRACK = 1;
	localparam int CHK_DIR = 2;
	localparam int NUM_CHECKS = 3;

	typedef struct packed {
		logic [1:0] mode;
		logic [15:0] to_signal;
		logic [15:0] to_track;
		logic [15:0] to_dir;
		logic [15:0] lines;
	} cfg_s;

	typedef enum {MON_IDLE, MON_ARMED, MON_TRIPPED} mon_state_e;

endpackage

`default_nettype wire

// ===== logic/check_timer.sv
/*
 * Millisecond timeout counter for one sensor check.
 * Assumes ms_tick is a one-cycle pulse on hclk; cond and run are hclk logic.
 */
`timescale 1ns/100ps
`default_nettype none

module check_timer
	import speed_monitor_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ms_tick,
	input wire logic run,
	input wire logic cond,
	input wire logic [15:0] timeout,
	output logic expired
);

	// ---------------------------------------------
	// Counter
	// ---------------------------------------------
	logic [15:0] count_reg;
	logic enabled;

	assign enabled = run && (timeout != 16'h0000);

	// Any gap in the condition restarts from zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= 16'h0000;
		end else if (!enabled || !cond) begin
			count_reg <= 16'h0000;
		end else if (ms_tick && count_reg <= timeout) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// The first tick may come at once, so one extra tick keeps the full time
	assign expired = enabled && cond && (count_reg > timeout);

	chk_zero_off: assert property (@(posedge hclk)
		disable iff (!hresetn) (timeout == 16'h0000) |-> !expired)
		else $error("check fired with zero timeout");
	chk_gap_restart: assert property (@(posedge hclk)
		disable iff (!hresetn) !cond |=> (count_reg == 16'h0000))
		else $error("check timing kept after condition gap");

endmodule // check_timer

`default_nettype wire

// ===== logic/quad_track_check.sv
/*
 * Four-fold quadrature decoder with track sequence and division mark check.
 * Assumes track and index inputs are already synchronised to hclk.
 */
`timescale 1ns/100ps
`default_nettype none

module quad_track_check
	import speed_monitor_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic track_a,
	input wire logic track_b,
	input wire logic index_mark,
	input wire logic expansion_present,
	input wire logic [15:0] lines,
	output logic step,
	output logic step_fwd,
	output logic track_bad
);

	// ---------------------------------------------
	// Edge decoding
	// ---------------------------------------------
	logic [1:0] prev_reg;
	logic [1:0] cur;
	logic illegal;
	logic bad_seq_reg;
	logic bad_marks_reg;
	logic index_prev_reg;
	logic seen_index_reg;
	logic [17:0] edge_cnt_reg;
	logic index_rise;

	assign cur = {track_a, track_b};
	// Both tracks changing at once has no legal order
	assign illegal = (prev_reg ^ cur) == 2'h3;
	assign step = (prev_reg != cur) && !illegal;
	assign step_fwd = prev_reg[0] ^ cur[1];
	assign index_rise = index_mark && !index_prev_reg;

	// Bad sequence holds until the next legal step
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_reg <= 2'h0;
			bad_seq_reg <= 1'b0;
		end else begin
			prev_reg <= cur;
			if (illegal) begin
				bad_seq_reg <= 1'b1;
			end else if (step) begin
				bad_seq_reg <= 1'b0;
			end
		end
	end

	// Edges per revolution must equal four times the line count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			index_prev_reg <= 1'b0;
			seen_index_reg <= 1'b0;
			edge_cnt_reg <= 18'h00000;
			bad_marks_reg <= 1'b0;
		end else begin
			index_prev_reg <= index_mark;
			if (!expansion_present) begin
				seen_index_reg <= 1'b0;
				bad_marks_reg <= 1'b0;
				edge_cnt_reg <= 18'h00000;
			end else if (index_rise) begin
				seen_index_reg <= 1'b1;
				// The step that lands with the mark opens the new turn
				edge_cnt_reg <= {17'h00000, step};
				bad_marks_reg <= seen_index_reg &&
					(edge_cnt_reg != {lines, 2'h0});
			end else if (step) begin
				edge_cnt_reg <= edge_cnt_reg + 18'h00001;
			end
		end
	end

	assign track_bad = bad_seq_reg || bad_marks_reg;

	chk_track_illegal: assert property (@(posedge hclk)
		disable iff (!hresetn) illegal |=> track_bad)
		else $error("illegal track order not flagged");

endmodule // quad_track_check

`default_nettype wire

// ===== logic/speed_sensor_fault_monitor.sv
/*
 * Speed sensor fault monitor: signal loss, track and direction checks
 * with millisecond timeouts, latched fault shutdown, AHB-Lite registers.
 * Assumes encoder pins and drive release/start are asynchronous, while
 * speed reference and measured speed come from hclk logic.
 */
// Design decisions made here: register access over AHB-Lite and the address map.
// Behaviour
// - Mode 0 disables all checks; mode 2 faults when a timeout expires.
// - Checks run only while drive release and start are both present.
// - A condition must hold unbroken for the timeout; any gap restarts.
// - A zero timeout disables just that check.
// - Three timeouts in ms, up to 65000, reset value 1000.
// - Zero measured speed with nonzero reference raises code 1430.
// - Invalid quadrature edge order for the track timeout raises 1430.
// - Speed sign differing from reference sign raises code 1432.
// - A quarter turn in the commanded direction clears direction timing.
// - With the expansion module, division marks per turn are checked.
// - Any expired check shuts the drive down and reports the code.
`timescale 1ns/100ps
`default_nettype none

module speed_sensor_fault_monitor
	import speed_monitor_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic enc_track_a,
	input wire logic enc_track_b,
	input wire logic enc_index,
	input wire logic encoder_expansion_module,
	input wire logic drive_release,
	input wire logic start_cmd,
	input wire logic [15:0] speed_ref,
	input wire logic [15:0] speed_meas,
	output logic drive_shutdown,
	output logic [15:0] fault_code
);

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	logic [5:0] pin_raw;
	logic [5:0] pin_meta_reg;
	logic [5:0] pin_sync_reg;

	assign pin_raw = {start_cmd, drive_release, encoder_expansion_module,
		enc_index, enc_track_b, enc_track_a};

	// Two flops per pin; only the second stage is read
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_meta_reg[gi] <= 1'b0;
					pin_sync_reg[gi] <= 1'b0;
				end else begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	// ---------------------------------------------
	// Millisecond tick
	// ---------------------------------------------
	logic [15:0] tick_cnt_reg;
	logic ms_tick_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_reg <= 16'h0000;
			ms_tick_reg <= 1'b0;
		end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 16'h0000;
			ms_tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			ms_tick_reg <= 1'b0;
		end
	end

	// ---------------------------------------------
	// AHB-Lite register slave
	// ---------------------------------------------
	cfg_s cfg_reg;
	logic [7:0] wr_addr_reg;
	logic wr_pend_reg;
	logic ack_pulse_reg;
	logic [31:0] status_word;
	logic addr_ok;
	mon_state_e state_reg;
	logic [NUM_CHECKS-1:0] cause_reg;
	logic armed;

	// Word offset decode shared by read and write paths
	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		unique case (a)
			OFS_CTRL: reg_sel = 3'h1;
			OFS_TO_SIGNAL: reg_sel = 3'h2;
			OFS_TO_TRACK: reg_sel = 3'h3;
			OFS_TO_DIR: reg_sel = 3'h4;
			OFS_LINES: reg_sel = 3'h5;
			OFS_STATUS: reg_sel = 3'h6;
			default: reg_sel = 3'h0;
		endcase
	endfunction

	// Values above the documented maximum saturate rather than wrap
	function automatic logic [15:0] clamp_to(input logic [15:0] v);
		clamp_to = (v > TIMEOUT_MAX) ? TIMEOUT_MAX : v;
	endfunction

	assign addr_ok = hsel && htrans[1] && hready && (hsize == 3'h2) &&
		(haddr[31:8] == 24'h000000);
	assign status_word = {fault_code, 8'h00, 3'h0, armed, drive_shutdown,
		cause_reg};

	// Zero wait states; OKAY always, unmapped offsets in the low 256 bytes read zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= addr_ok && hwrite;
			wr_addr_reg <= haddr[7:0];
			if (addr_ok && !hwrite) begin
				unique case (reg_sel(haddr[7:0]))
					3'h1: hrdata <= {30'h00000000, cfg_reg.mode};
					3'h2: hrdata <= {16'h0000, cfg_reg.to_signal};
					3'h3: hrdata <= {16'h0000, cfg_reg.to_track};
					3'h4: hrdata <= {16'h0000, cfg_reg.to_dir};
					3'h5: hrdata <= {16'h0000, cfg_reg.lines};
					3'h6: hrdata <= status_word;
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg.mode <= MODE_OFF;
			cfg_reg.to_signal <= TIMEOUT_RESET;
			cfg_reg.to_track <= TIMEOUT_RESET;
			cfg_reg.to_dir <= TIMEOUT_RESET;
			cfg_reg.lines <= LINES_RESET;
			ack_pulse_reg <= 1'b0;
		end else begin
			ack_pulse_reg <= 1'b0;
			if (wr_pend_reg) begin
				unique case (reg_sel(wr_addr_reg))
					3'h1: begin
						cfg_reg.mode <= hwdata[1:0];
						ack_pulse_reg <= hwdata[CTRL_ACK_BIT];
					end
					3'h2: cfg_reg.to_signal <= clamp_to(hwdata[15:0]);
					3'h3: cfg_reg.to_track <= clamp_to(hwdata[15:0]);
					3'h4: cfg_reg.to_dir <= clamp_to(hwdata[15:0]);
					3'h5: cfg_reg.lines <= hwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------
	// Check conditions
	// ---------------------------------------------
	logic step;
	logic step_fwd;
	logic track_bad;
	logic mismatch;
	logic [15:0] progress_reg;
	logic dir_clear_reg;
	logic [NUM_CHECKS-1:0] cond;
	logic [NUM_CHECKS-1:0] expired;
	logic [15:0] timeouts [NUM_CHECKS];

	// Only mode 2 with release and start present arms the checks
	assign armed = (cfg_reg.mode == MODE_ERROR) && pin_sync_reg[4] &&
		pin_sync_reg[5];

	quad_track_check u_track (
		.hclk(hclk),
		.hresetn(hresetn),
		.track_a(pin_sync_reg[0]),
		.track_b(pin_sync_reg[1]),
		.index_mark(pin_sync_reg[2]),
		.expansion_present(pin_sync_reg[3]),
		.lines(cfg_reg.lines),
		.step(step),
		.step_fwd(step_fwd),
		.track_bad(track_bad)
	);

	assign mismatch = (speed_ref != 16'h0000) && (speed_meas != 16'h0000) &&
		(speed_ref[15] != speed_meas[15]);

	// Count steps in the commanded direction; a quarter turn is one line
	// count under four-fold evaluation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			progress_reg <= 16'h0000;
			dir_clear_reg <= 1'b0;
		end else begin
			dir_clear_reg <= 1'b0;
			if (!mismatch || !armed) begin
				progress_reg <= 16'h0000;
			end else if (progress_reg >= cfg_reg.lines) begin
				progress_reg <= 16'h0000;
				dir_clear_reg <= 1'b1;
			end else if (step && (step_fwd == !speed_ref[15])) begin
				progress_reg <= progress_reg + 16'h0001;
			end
		end
	end

	assign cond[CHK_SIGNAL] = (speed_meas == 16'h0000) &&
		(speed_ref != 16'h0000);
	assign cond[CHK_TRACK] = track_bad;
	assign cond[CHK_DIR] = mismatch && !dir_clear_reg;
	assign timeouts[CHK_SIGNAL] = cfg_reg.to_signal;
	assign timeouts[CHK_TRACK] = cfg_reg.to_track;
	assign timeouts[CHK_DIR] = cfg_reg.to_dir;

	// One independent timer per check
	generate
		for (gi = 0; gi < NUM_CHECKS; gi++) begin : g_chk
			check_timer u_timer (
				.hclk(hclk),
				.hresetn(hresetn),
				.ms_tick(ms_tick_reg),
				.run(armed),
				.cond(cond[gi]),
				.timeout(timeouts[gi]),
				.expired(expired[gi])
			);
		end
	endgenerate

	// ---------------------------------------------
	// Fault latch and shutdown
	// ---------------------------------------------
	mon_state_e state_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			MON_IDLE: begin
				if (armed) begin
					state_next = MON_ARMED;
				end
			end
			MON_ARMED: begin
				if (|expired) begin
					state_next = MON_TRIPPED;
				end else if (!armed) begin
					state_next = MON_IDLE;
				end
			end
			MON_TRIPPED: begin
				// A new expiry in the ack cycle keeps the trip
				if (ack_pulse_reg && !(|expired)) begin
					state_next = MON_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= MON_IDLE;
			drive_shutdown <= 1'b0;
		end else begin
			state_reg <= state_next;
			drive_shutdown <= (state_next == MON_TRIPPED);
		end
	end

	// Sticky causes; a set in the ack cycle wins over the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_reg <= 3'h0;
			fault_code <= CODE_NONE;
		end else begin
			cause_reg <= (ack_pulse_reg ? 3'h0 : cause_reg) | expired;
			if (|expired[CHK_TRACK:CHK_SIGNAL]) begin
				fault_code <= CODE_SIGNAL;
			end else if (expired[CHK_DIR]) begin
				fault_code <= CODE_DIR;
			end else if (ack_pulse_reg) begin
				fault_code <= CODE_NONE;
			end
		end
	end

	chk_unarmed_quiet: assert property (@(posedge hclk)
		disable iff (!hresetn) !armed |-> ##1 !$rose(drive_shutdown))
		else $error("shutdown raised while not armed");
	chk_mode_off: assert property (@(posedge hclk)
		disable iff (!hresetn) (cfg_reg.mode == MODE_OFF) |-> !(|expired))
		else $error("check expired in mode off");
	chk_trip_report: assert property (@(posedge hclk)
		disable iff (!hresetn) (state_reg == MON_ARMED && |expired) |=>
		drive_shutdown && fault_code != CODE_NONE)
		else $error("expired check without shutdown and code");
	chk_dir_code: assert property (@(posedge hclk)
		disable iff (!hresetn) (expired == 3'h4) |=> fault_code == CODE_DIR)
		else $error("direction fault code wrong");
	chk_latch_hold: assert property (@(posedge hclk)
		disable iff (!hresetn) drive_shutdown && !ack_pulse_reg |=> drive_shutdown)
		else $error("fault released without acknowledge");
	chk_tick_gap: assert property (@(posedge hclk)
		disable iff (!hresetn) ms_tick_reg |=> !ms_tick_reg)
		else $error("millisecond tick too fast");

endmodule // speed_sensor_fault_monitor

`default_nettype wire

// ===== sim/quad_encoder_model.sv
/*
 * Incremental quadrature encoder on the motor shaft, one step per two cycles.
 * Assumes the bench picks motion: 0 still, 1 forward, 2 broken sequence.
 */
`timescale 1ns/100ps
`default_nettype none

module quad_encoder_model (
	input wire logic hclk,
	input wire logic [1:0] motion,
	input wire logic [7:0] idx_steps,
	output logic track_a,
	output logic track_b,
	output logic index_mark
);
	// ---------------------------------------------
	// Shaft position
	// ---------------------------------------------
	logic [1:0] phase_reg = 2'h0;
	logic [7:0] count_reg = 8'h00;
	logic half_reg = 1'b0;

	// Step on every second edge so each level outlasts the pin sync
	always @(posedge hclk) begin
		half_reg <= ~half_reg;
		if (half_reg && motion == 2'h1) begin
			phase_reg <= phase_reg + 2'h1;
			if (count_reg + 8'h01 >= idx_steps)
				count_reg <= 8'h00;
			else
				count_reg <= count_reg + 8'h01;
		end else if (half_reg && motion == 2'h2) begin
			phase_reg <= phase_reg + 2'h2; // Both tracks flip
		end
	end

	// Gray code, track A leads B when turning forward
	assign track_a = phase_reg[1] ^ phase_reg[0];
	assign track_b = phase_reg[1];
	assign index_mark = (count_reg == 8'h00); // One mark per wrap
endmodule // quad_encoder_model

`default_nettype wire

// ===== sim/tb_top.sv
/*
 * Self-checking bench of the speed sensor fault monitor.
 * Assumes the monitor package and design files are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import speed_monitor_pkg::*;
;
	// ---------------------------------------------
	// Signals
	// ---------------------------------------------
	localparam int TICK = 4;
	localparam int TO = 3;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd, lfsr_state;
	logic [1:0] htrans, motion;
	logic [2:0] hsize;
	logic enc_a, enc_b, enc_idx, expansion, rel, start, drive_shutdown;
	logic [15:0] sref, smeas, fault_code;
	logic [7:0] idx_steps;
	int failures, samples_checked, cycles;
	logic [31:0] rst_tab [7] = '{32'h0, 32'h3e8, 32'h3e8, 32'h3e8,
		32'h400, 32'h0, 32'h0};

	// Short tick keeps each millisecond at four cycles
	speed_sensor_fault_monitor #(.TICK_CYCLES(TICK)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .enc_track_a(enc_a), .enc_track_b(enc_b),
		.enc_index(enc_idx), .encoder_expansion_module(expansion),
		.drive_release(rel), .start_cmd(start), .speed_ref(sref),
		.speed_meas(smeas), .drive_shutdown(drive_shutdown),
		.fault_code(fault_code));

	quad_encoder_model u_enc (.hclk(hclk), .motion(motion),
		.idx_steps(idx_steps), .track_a(enc_a), .track_b(enc_b),
		.index_mark(enc_idx));

	// ---------------------------------------------
	// Model, stimulus helpers and comparisons
	// ---------------------------------------------
	// Code that the checks should latch; signal and track share one code
	function automatic int model_code(int mode, int arm, int sig, int trk,
		int dir);
		if (mode != 2 || arm == 0)
			return 0;
		if (sig != 0 || trk != 0)
			return 'h1430;
		return (dir != 0) ? 'h1432 : 0;
	endfunction

	// Positive nonzero speed from the shift register
	function automatic logic [15:0] rnd();
		lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^
			lfsr_state[1] ^ lfsr_state[0]};
		return {1'b0, lfsr_state[14:1], 1'b1};
	endfunction

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t reg got %h exp %h", $time, got, exp);
		end
	endtask

	// Shutdown must track whether a code is latched
	task automatic check_out(input int exp);
		logic [15:0] e;
		e = exp[15:0];
		samples_checked++;
		if (fault_code !== e || drive_shutdown !== (e != 16'h0000)) begin
			failures++;
			$display("CHECK FAILED %0t code %h exp %h", $time, fault_code, e);
		end
	endtask

	// One single word transfer; hready is waited on, never assumed
	task automatic ahb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		ahb(a, 1'b0, 32'h0);
		check_word(rd, exp);
		check_word({31'h0, hresp}, 32'h0);
	endtask

	// Latched outputs, so one look at the end covers the whole stretch
	task automatic quiet(input int n);
		repeat (n) @(posedge hclk);
		check_out(0);
	endtask

	task automatic trip(input int lo, input int hi, input int code);
		int n;
		n = 0;
		repeat (lo) @(posedge hclk);
		check_out(0);
		while (drive_shutdown !== 1'b1 && n < hi) begin
			@(posedge hclk);
			n++;
		end
		check_out(code);
	endtask

	task automatic ack();
		ahb(OFS_CTRL, 1'b1, 32'h00000102);
		repeat (3) @(posedge hclk);
		check_out(0);
	endtask

	task automatic finish_test();
		$display("compares %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ---------------------------------------------
	// Clock, hang guard and main sequence
	// ---------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// Run needs about 1000 cycles; far beyond that means a hang
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hsize = 3'b010;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		{rel, start, expansion} = 3'b000;
		{sref, smeas} = 32'h0;
		motion = 2'h0;
		idx_steps = 8'h10;
		lfsr_state = 32'h9d31;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 7; i++)
			rd_check(8'(i * 4), rst_tab[i]);
		ahb(OFS_TO_SIGNAL, 1'b1, 32'h0000ffff);
		rd_check(OFS_TO_SIGNAL, 32'h0000fde8);
		for (int i = 1; i < 4; i++)
			ahb(8'(i * 4), 1'b1, 32'(TO));
		ahb(OFS_LINES, 1'b1, 32'h4);
		// Signal loss present but every mode other than 2 stays silent
		rel <= 1'b1;
		start <= 1'b1;
		sref <= rnd();
		for (int m = 0; m < 4; m++) begin
			if (m != 2) begin
				ahb(OFS_CTRL, 1'b1, 32'(m));
				quiet(4 * TICK * TO);
			end
		end
		start <= 1'b0;
		ahb(OFS_CTRL, 1'b1, 32'h2);
		quiet(4 * TICK * TO);
		start <= 1'b1;
		// Gaps of one cycle keep restarting the timer
		repeat (3) begin
			smeas <= 16'h0000;
			repeat (TICK * TO - 2) @(posedge hclk);
			smeas <= rnd();
			@(posedge hclk);
		end
		check_out(0);
		smeas <= 16'h0000;
		trip(TICK * TO - 2, TICK + 8, model_code(2, 1, 1, 0, 0));
		sref <= 16'h0000;
		repeat (20) @(posedge hclk);
		check_out('h1430);
		rd_check(OFS_STATUS, 32'h14300019);
		ack();
		ahb(OFS_TO_SIGNAL, 1'b1, 32'h0);
		sref <= rnd();
		quiet(4 * TICK * TO);
		smeas <= 16'h0000 - rnd();
		ahb(OFS_TO_SIGNAL, 1'b1, 32'(TO));
		trip(TICK * TO - 4, TICK + 10, model_code(2, 1, 0, 0, 1));
		rd_check(OFS_STATUS, 32'h1432001c);
		smeas <= rnd();
		ack();
		// Forward quarter turns keep clearing the direction timing
		smeas <= 16'h0000 - rnd();
		motion <= 2'h1;
		quiet(60);
		motion <= 2'h0;
		trip(TICK * TO - 2, TICK + 10, model_code(2, 1, 0, 0, 1));
		smeas <= rnd();
		ack();
		motion <= 2'h2;
		trip(TICK * TO - 2, TICK + 10, model_code(2, 1, 0, 1, 0));
		// A legal step ends the bad sequence before the trip is cleared
		motion <= 2'h1;
		repeat (8) @(posedge hclk);
		motion <= 2'h0;
		ack();
		motion <= 2'h1;
		repeat (100) @(posedge hclk);
		expansion <= 1'b1;
		quiet(150);
		idx_steps <= 8'h14;
		trip(0, 300, model_code(2, 1, 0, 1, 0));
		finish_test();
	end
endmodule // tb_top

`default_nettype wire
